// File: kpd_pkg.sv
// package: register map, field positions and carrier types of the key pin interrupt block
package kpd_pkg;
  // ****************************************************************
  // widths
  // ****************************************************************
  localparam int unsigned PIN_COUNT  = 8;         // number of key input pins
  localparam int unsigned ADDR_WIDTH = 2;         // register address width
  localparam int unsigned DATA_WIDTH = 8;         // register data width

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;  // status and control
  localparam logic [1:0] ADDR_PIN_ENABLE     = 2'h1;  // pin enables
  localparam logic [1:0] ADDR_POLARITY       = 2'h2;  // polarity selects
  localparam logic [1:0] ADDR_IRQ_STATUS     = 2'h3;  // sticky event status, write one clears

  // ****************************************************************
  // status_control_reg field positions
  // ****************************************************************
  localparam int unsigned BIT_MODE   = 0;         // detect_mode_select
  localparam int unsigned BIT_IRQ_EN = 1;         // irq_enable
  localparam int unsigned BIT_ACK    = 2;         // flag_acknowledge
  localparam int unsigned BIT_FLAG   = 3;         // detect_flag

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;      // every register resets to zero

  // register bus request
  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;                  // register address
    logic [DATA_WIDTH-1:0] wdata;                 // write data
    logic                  write_strobe;          // one-cycle write
    logic                  read_strobe;           // one-cycle read
  } kpd_bus_req_type;

  // decoded detector controls
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_enable_bits;        // per-pin enables
    logic [PIN_COUNT-1:0] polarity_select_bits;   // per-pin polarity
    logic                 detect_mode_select;     // 0 edge, 1 edge and level
    logic                 ack_strobe;             // one-cycle clear request
  } kpd_detect_ctrl_type;

  // detector results
  typedef struct packed {
    logic detect_flag;                            // shared detect flag
    logic edge_event;                             // one-cycle: valid edge seen
    logic any_asserted;                           // level: some enabled pin asserted
  } kpd_detect_stat_type;
endpackage

// File: kpd_sync.sv
// two-flop synchroniser for the key input pins
`timescale 1ns/1ps
`default_nettype none
module kpd_sync
  import kpd_pkg::*;
(
  input  wire logic                 clk,          // bus clock
  input  wire logic                 reset,        // async reset, active high
  input  wire logic [PIN_COUNT-1:0] pins_async,   // raw pins
  output logic      [PIN_COUNT-1:0] pins_sync     // synchronised pins
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PIN_COUNT-1:0] stage1;                 // first flop, read only by stage2
    logic [PIN_COUNT-1:0] stage2;                 // second flop
  } kpd_sync_state_type;

  kpd_sync_state_type state_reg;                  // registered state
  kpd_sync_state_type state_next;                 // next state

  // shift the pins through both stages
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = pins_async;
    state_next.stage2 = state_reg.stage1;
  end

  // register the state; pins idle high is not assumed, reset to zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pins_sync = state_reg.stage2;
endmodule
`default_nettype wire

// File: kpd_detect.sv
// edge and level detector with the shared detect flag
`timescale 1ns/1ps
`default_nettype none
module kpd_detect
  import kpd_pkg::*;
(
  input  wire logic                 clk,          // bus clock
  input  wire logic                 reset,        // async reset, active high
  input  wire logic [PIN_COUNT-1:0] pins,         // synchronised pins
  input  var  kpd_detect_ctrl_type  ctrl,         // controls from registers
  output var kpd_detect_stat_type   stat          // flag and events
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PIN_COUNT-1:0] prev;                   // previous asserted view
    logic                 armed;                  // edges may be recognised
    logic                 flag;                   // detect flag
  } kpd_det_state_type;

  kpd_det_state_type    state_reg;                // registered state
  kpd_det_state_type    state_next;               // next state
  logic [PIN_COUNT-1:0] asserted;                 // pins at asserted level, enabled only
  logic [PIN_COUNT-1:0] rise;                     // per-pin deasserted->asserted

  // per-pin asserted view: polarity 0 low, 1 high; disabled pins masked
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin
      assign asserted[g] = ctrl.pin_enable_bits[g] &
                           (pins[g] ~^ ctrl.polarity_select_bits[g]);
      // deasserted sample then asserted sample
      assign rise[g] = asserted[g] & ~state_reg.prev[g];
    end
  endgenerate

  // next-state: arming, flag set and clear
  always_comb begin
    logic any_on;
    logic edge_ok;
    any_on  = |asserted;
    edge_ok = state_reg.armed & (|rise);
    state_next      = state_reg;
    state_next.prev = asserted;
    // re-arm only once every enabled input is back at its deasserted level
    if (edge_ok) begin
      state_next.armed = 1'b0;
    end else if (!any_on) begin
      state_next.armed = 1'b1;
    end
    // clear first, then set so a coincident event wins
    if (ctrl.ack_strobe) begin
      if (!ctrl.detect_mode_select || !any_on) begin
        state_next.flag = 1'b0;
      end
    end
    if (edge_ok) begin
      state_next.flag = 1'b1;
    end else if (ctrl.detect_mode_select && any_on) begin
      state_next.flag = 1'b1;
    end
  end

  // register the state; armed after reset since nothing is enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '{prev: '0, armed: 1'b1, flag: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // one driver for the whole result bundle
  assign stat = '{detect_flag:  state_reg.flag,
                  edge_event:   state_reg.armed & (|rise),
                  any_asserted: |asserted};

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_edge_sets_flag: assert property (@(posedge clk) disable iff (reset)
    (state_reg.armed && |rise) |=> state_reg.flag)
    else $error("valid edge did not set detect flag");
  a_level_holds_flag: assert property (@(posedge clk) disable iff (reset)
    (ctrl.detect_mode_select && |asserted) |=> state_reg.flag)
    else $error("flag cleared while an enabled input is asserted");
  a_edge_ack_clears: assert property (@(posedge clk) disable iff (reset)
    (ctrl.ack_strobe && !ctrl.detect_mode_select && !(state_reg.armed && |rise))
    |=> !state_reg.flag)
    else $error("acknowledge did not clear flag in edge mode");
  a_disarm_after_edge: assert property (@(posedge clk) disable iff (reset)
    (state_reg.armed && |rise) |=> !state_reg.armed)
    else $error("detector stayed armed after an edge");
  a_flag_needs_cause: assert property (@(posedge clk) disable iff (reset)
    (!state_reg.flag && !(state_reg.armed && |rise)
     && !(ctrl.detect_mode_select && |asserted)) |=> !state_reg.flag)
    else $error("flag set without a cause");
  c_edge_event: cover property (@(posedge clk) disable iff (reset)
    state_reg.armed && |rise);
  c_level_blocks_ack: cover property (@(posedge clk) disable iff (reset)
    ctrl.ack_strobe && ctrl.detect_mode_select && |asserted);
endmodule
`default_nettype wire

// File: kpd_top.sv
// key pin interrupt block: register port, interrupt status and detector
`timescale 1ns/1ps
`default_nettype none
module kpd_top
  import kpd_pkg::*;
(
  input  wire logic                  clk,          // bus clock, 40 MHz
  input  wire logic                  reset,        // async reset, active high
  input  wire logic [ADDR_WIDTH-1:0] addr,         // register address
  input  wire logic [DATA_WIDTH-1:0] wdata,        // write data
  input  wire logic                  write_strobe, // one-cycle write
  input  wire logic                  read_strobe,  // one-cycle read
  output logic      [DATA_WIDTH-1:0] rdata,        // read data, cycle after read
  input  wire logic [PIN_COUNT-1:0]  key_input_pins, // external key pins
  output logic                       irq_request,  // request to the core
  output logic                       event_irq     // status/mask event interrupt
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [PIN_COUNT-1:0] pin_enable;             // pin_enable_reg
    logic [PIN_COUNT-1:0] polarity;               // polarity_select_reg
    logic                 mode;                   // detect_mode_select
    logic                 irq_en;                 // irq_enable
    logic                 ack;                    // one-cycle flag_acknowledge
    logic [1:0]           ev_status;              // sticky: 0 flag rise, 1 edge seen
    logic [1:0]           ev_mask;                // event mask, same layout
    logic [DATA_WIDTH-1:0] rdata;                 // read data
  } kpd_top_state_type;

  localparam int unsigned EV_FLAG = 0;            // event bit: flag set
  localparam int unsigned EV_EDGE = 1;            // event bit: edge recognised

  kpd_top_state_type    state_reg;                // registered state
  kpd_top_state_type    state_next;               // next state
  kpd_bus_req_type      req;                      // bundled bus request
  logic [PIN_COUNT-1:0] pins_sync;                // synchronised pins
  kpd_detect_ctrl_type  dctrl;                    // detector controls
  kpd_detect_stat_type  dstat;                    // detector results
  logic                 flag_d;                   // flag one cycle ago

  assign req = '{addr: addr, wdata: wdata, write_strobe: write_strobe,
                 read_strobe: read_strobe};

  // status_control_reg read view; acknowledge reads zero
  function automatic logic [7:0] sc_view(input logic flag, input logic ien,
                                          input logic md);
    logic [7:0] v;
    v             = RESET_BYTE;
    v[BIT_FLAG]   = flag;
    v[BIT_IRQ_EN] = ien;
    v[BIT_MODE]   = md;
    return v;
  endfunction

  // ****************************************************************
  // pin synchroniser and detector
  // ****************************************************************
  kpd_sync kpd_sync_inst (
    .clk        (clk),
    .reset      (reset),
    .pins_async (key_input_pins),
    .pins_sync  (pins_sync)
  );

  assign dctrl = '{pin_enable_bits: state_reg.pin_enable,
                   polarity_select_bits: state_reg.polarity,
                   detect_mode_select: state_reg.mode,
                   ack_strobe: state_reg.ack};

  kpd_detect kpd_detect_inst (
    .clk   (clk),
    .reset (reset),
    .pins  (pins_sync),
    .ctrl  (dctrl),
    .stat  (dstat)
  );

  // ****************************************************************
  // register writes, reads and event status
  // ****************************************************************
  always_comb begin
    state_next       = state_reg;
    state_next.ack   = 1'b0;
    state_next.rdata = RESET_BYTE;
    if (req.write_strobe) begin
      case (req.addr)
        ADDR_STATUS_CONTROL: begin
          // flag bit position is ignored on write
          state_next.mode   = req.wdata[BIT_MODE];
          state_next.irq_en = req.wdata[BIT_IRQ_EN];
          state_next.ack    = req.wdata[BIT_ACK];
        end
        ADDR_PIN_ENABLE: begin
          // a newly enabled asserted pin may flag at once
          state_next.pin_enable = req.wdata;
        end
        ADDR_POLARITY: begin
          state_next.polarity = req.wdata;
        end
        ADDR_IRQ_STATUS: begin
          state_next.ev_status = state_reg.ev_status & ~req.wdata[1:0];
          state_next.ev_mask   = req.wdata[5:4];
        end
        default: begin
          state_next.ack = 1'b0;                  // unmapped: ignored
        end
      endcase
    end
    // events set after clear so they win
    if (dstat.detect_flag && !flag_d) begin
      state_next.ev_status[EV_FLAG] = 1'b1;
    end
    if (dstat.edge_event) begin
      state_next.ev_status[EV_EDGE] = 1'b1;
    end
    if (req.read_strobe) begin
      case (req.addr)
        ADDR_STATUS_CONTROL: begin
          state_next.rdata = sc_view(dstat.detect_flag, state_reg.irq_en, state_reg.mode);
        end
        ADDR_PIN_ENABLE: begin
          state_next.rdata = state_reg.pin_enable;
        end
        ADDR_POLARITY: begin
          state_next.rdata = state_reg.polarity;
        end
        ADDR_IRQ_STATUS: begin
          state_next.rdata = {2'h0, state_reg.ev_mask, 2'h0, state_reg.ev_status};
        end
        default: begin
          state_next.rdata = RESET_BYTE;
        end
      endcase
    end
  end

  // register the state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      flag_d    <= 1'b0;
    end else begin
      state_reg <= state_next;
      flag_d    <= dstat.detect_flag;
    end
  end

  assign rdata       = state_reg.rdata;
  assign irq_request = dstat.detect_flag & state_reg.irq_en;
  assign event_irq   = |(state_reg.ev_status & state_reg.ev_mask);

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_irq_follows_flag: assert property (@(posedge clk) disable iff (reset)
    irq_request == (dstat.detect_flag && state_reg.irq_en))
    else $error("irq request does not follow flag and enable");
  a_ack_one_cycle: assert property (@(posedge clk) disable iff (reset)
    state_reg.ack |=> !state_reg.ack || $past(req.write_strobe))
    else $error("acknowledge strobe held longer than one cycle");
  a_ack_reads_zero: assert property (@(posedge clk) disable iff (reset)
    (req.read_strobe && req.addr == ADDR_STATUS_CONTROL) |=> !rdata[BIT_ACK])
    else $error("acknowledge bit read back as one");
  c_irq_raised: cover property (@(posedge clk) disable iff (reset) irq_request);
  c_event_irq: cover property (@(posedge clk) disable iff (reset) event_irq);
endmodule
`default_nettype wire

// File: kpd_key_model.sv
// partner model: switches that drive the key input lines
`timescale 1ns/1ps
`default_nettype none
module kpd_key_model
  import kpd_pkg::*;
(
  input  wire logic                 clk,            // bench clock, places changes off the edge
  input  wire logic [PIN_COUNT-1:0] press_level,    // wanted level of each line
  output var  logic [PIN_COUNT-1:0] key_input_pins  // lines into the block
);
  // ****************************************************************
  // switch lines
  // ****************************************************************
  // lines start released high and are always driven, so no floating value reaches the block
  initial begin
    key_input_pins = 8'hff;
  end

  // a switch settles 7 ns after the clock edge that follows the request, away from the sampling edge
  always @(posedge clk) begin
    key_input_pins <= #7 press_level;
  end
endmodule
`default_nettype wire

// File: kpd_top_bench.sv
// self-checking bench for the key pin interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module kpd_top_bench
  import kpd_pkg::*;
;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic                  clk;             // bus clock, 40 MHz
  logic                  reset;           // async reset, active high
  logic [ADDR_WIDTH-1:0] addr;            // register address
  logic [DATA_WIDTH-1:0] wdata;           // write data
  logic [DATA_WIDTH-1:0] rdata;           // read data
  logic                  write_strobe;    // write pulse
  logic                  read_strobe;     // read pulse
  logic [PIN_COUNT-1:0]  press_level;     // requested switch levels
  logic [PIN_COUNT-1:0]  key_input_pins;  // switch lines
  logic                  irq_request;     // core request
  logic                  event_irq;       // status interrupt
  int                    error_cnt;       // mismatches
  int                    n_compared;      // comparisons made

  kpd_top kpd_top_inst (
    .clk            (clk),
    .reset          (reset),
    .addr           (addr),
    .wdata          (wdata),
    .write_strobe   (write_strobe),
    .read_strobe    (read_strobe),
    .rdata          (rdata),
    .key_input_pins (key_input_pins),
    .irq_request    (irq_request),
    .event_irq      (event_irq)
  );

  kpd_key_model kpd_key_model_inst (
    .clk            (clk),
    .press_level    (press_level),
    .key_input_pins (key_input_pins)
  );

  // ****************************************************************
  // clock and time zero values
  // ****************************************************************
  // half period of 12.5 ns
  always #12.5 clk = ~clk;

  initial begin
    clk          = 1'b0;
    reset        = 1'b1;
    addr         = 2'h0;
    wdata        = 8'h00;
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
    press_level  = 8'hff;
    error_cnt    = 0;
    n_compared   = 0;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  // one-cycle write, then time for the ack strobe and flag to settle
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    addr         <= a;
    wdata        <= v;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // one-cycle read, data taken in the following cycle only
  task automatic chk_reg(input logic [1:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    addr        <= a;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    #1;
    `CHK(name, exp, rdata)
  endtask

  // change switch levels, then allow sync and flag latency plus the switch delay
  task automatic press(input logic [7:0] v);
    @(posedge clk);
    press_level <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask

  // bounded wait for the core request level
  task automatic wait_irq(input logic exp);
    int i;
    for (i = 0; i < 8 && irq_request !== exp; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("irq_request", exp, irq_request)
    // a used-up bound ends the run at once
    if (irq_request !== exp) begin
      tally_and_finish();
    end
  endtask

  // counts, verdict and end of run
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // hang guard
  // ****************************************************************
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    // every register resets to zero
    for (int a = 0; a < 4; a++) chk_reg(a[1:0], RESET_BYTE, "reset value");
    // init: mask, falling polarity, enable pins 0 and 1, ack, clear status, unmask
    wr(ADDR_STATUS_CONTROL, 8'h00);
    wr(ADDR_POLARITY, 8'h00);
    wr(ADDR_PIN_ENABLE, 8'h03);
    wr(ADDR_STATUS_CONTROL, 8'h04);
    wr(ADDR_IRQ_STATUS, 8'h13);
    wr(ADDR_STATUS_CONTROL, 8'h02);
    chk_reg(ADDR_STATUS_CONTROL, 8'h02, "sc after init");
    chk_reg(ADDR_PIN_ENABLE, 8'h03, "pin enable readback");
    // falling edge on pin 0
    press(8'hfe);
    wait_irq(1'b1);
    chk_reg(ADDR_STATUS_CONTROL, 8'h0a, "sc falling edge");
    chk_reg(ADDR_IRQ_STATUS, 8'h13, "event status");
    `CHK("event_irq unmasked", 1'b1, event_irq)
    wr(ADDR_IRQ_STATUS, 8'h03);
    `CHK("event_irq cleared", 1'b0, event_irq)
    // writing a zero to the flag position leaves it set
    wr(ADDR_STATUS_CONTROL, 8'h02);
    chk_reg(ADDR_STATUS_CONTROL, 8'h0a, "sc flag write");
    // edge mode ack clears even with pin 0 held low
    wr(ADDR_STATUS_CONTROL, 8'h06);
    chk_reg(ADDR_STATUS_CONTROL, 8'h02, "sc ack edge mode");
    wait_irq(1'b0);
    // pin 1 falls while pin 0 still asserted: not armed
    press(8'hfc);
    chk_reg(ADDR_STATUS_CONTROL, 8'h02, "sc not armed");
    press(8'hff);
    // disabled pin 2 never counts
    press(8'hfb);
    chk_reg(ADDR_STATUS_CONTROL, 8'h02, "sc disabled pin");
    press(8'hff);
    // a one written to the flag position does not set it
    wr(ADDR_STATUS_CONTROL, 8'h0a);
    chk_reg(ADDR_STATUS_CONTROL, 8'h02, "sc flag set write");
    // re-armed: pin 1 falls
    press(8'hfd);
    chk_reg(ADDR_STATUS_CONTROL, 8'h0a, "sc rearmed");
    press(8'hff);
    wr(ADDR_STATUS_CONTROL, 8'h06);
    // rising polarity on pin 0 with the request masked
    wr(ADDR_STATUS_CONTROL, 8'h00);
    press(8'hfe);
    wr(ADDR_POLARITY, 8'h01);
    chk_reg(ADDR_POLARITY, 8'h01, "polarity readback");
    wr(ADDR_STATUS_CONTROL, 8'h04);
    chk_reg(ADDR_STATUS_CONTROL, 8'h00, "sc before rise");
    press(8'hff);
    chk_reg(ADDR_STATUS_CONTROL, 8'h08, "sc rising edge");
    `CHK("irq_request masked", 1'b0, irq_request)
    // level mode: ack refused while pin 0 held high
    wr(ADDR_STATUS_CONTROL, 8'h01);
    wr(ADDR_STATUS_CONTROL, 8'h05);
    chk_reg(ADDR_STATUS_CONTROL, 8'h09, "sc level held");
    press(8'hfe);
    wr(ADDR_STATUS_CONTROL, 8'h05);
    chk_reg(ADDR_STATUS_CONTROL, 8'h01, "sc level released");
    press(8'hff);
    wr(ADDR_STATUS_CONTROL, 8'h03);
    wait_irq(1'b1);
    // status bits set but masked, then the edge bit unmasked
    chk_reg(ADDR_IRQ_STATUS, 8'h03, "event status masked");
    `CHK("event_irq masked", 1'b0, event_irq)
    wr(ADDR_IRQ_STATUS, 8'h20);
    `CHK("event_irq edge mask", 1'b1, event_irq)
    tally_and_finish();
  end
endmodule
`default_nettype wire
